// ### hdl/sdc_params.svh
// Constants for the SPI-DAC configuration register bank.
// Assumes inclusion by the package and the design and checker files.
//
// Behaviour
// (R1) The coil A command word, bits 15:0 of the command register, is sent just before each coil A current value.
// (R2) The coil B command word, bits 31:16 of the command register, is sent before each coil B current value.
// (R3) With SPI-DAC mode off, the low 24 bits of the command register act as the output switch velocity.
// (R4) The offset is the top byte of the offset register and is unsigned for absolute sine and cosine values.
// (R5) For mapped DAC values the offset byte is taken as signed.
// (R6) A read of the offset register address returns the sine and cosine start values in the low 24 bits.
// (R7) The coil A value following its command word is the 9-bit scaled sine current sent to the driver; the code sends its 10-bit sum with the offset.
// (R8) Each update frame is the command word then the current value within one chip-select assertion.
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define SDC_ADDR_CMD 7'h1d
`define SDC_ADDR_OFS 7'h7e
`define SDC_ADDR_VER 7'h7f

// ------------------------------------------------------------
// Reset values and identity
// ------------------------------------------------------------
`define SDC_CMD_RST 32'h0000_0000
`define SDC_OFS_RST 8'h00
// Arbitrary neutral version code
`define SDC_VERSION 16'h00a5

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define SDC_CMD_A_LSB 0
`define SDC_CMD_B_LSB 16
`define SDC_SW_VEL_W 24
`define SDC_OFS_LSB 24
`define SDC_COS_LSB 16
`define SDC_CUR_W 9
`define SDC_FRAME_BITS 32
`define SDC_SCK_DIV 8'h01

`endif

// ### hdl/sdc_pkg.sv
// Types for the SPI-DAC configuration register bank.
// Assumes sdc_params.svh is on the include path.
`include "sdc_params.svh"
package sdc_pkg;
    // Register bus request, one access per cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [31:0] wdata;
    } sdc_req_s;

    // Current values from the sequencer
    typedef struct packed {
        logic [8:0] cur_a;
        logic [8:0] cur_b;
        logic [7:0] sine_start_value;
        logic [7:0] start_cos;
    } sdc_cur_s;

    typedef enum logic [1:0] {SDC_IDLE, SDC_SHIFT, SDC_GAP} sdc_state_e;

    // Serial shifter state
    typedef struct packed {
        sdc_state_e st;
        logic [31:0] shreg;
        logic [5:0] bitcnt;
        logic [7:0] div;
        logic sck;
        logic cs_n;
        logic busy;
    } sdc_shift_s;
endpackage

// ### hdl/sdc_regs.sv
// SPI-DAC configuration register bank with its DAC frame sequencer.
// Assumes a single-cycle register port on sys_clk_i and current values on the same clock.
`timescale 1ns/10ps
`include "sdc_params.svh"
module sdc_regs
    import sdc_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 25 MHz
    input wire logic resetn_i, // Async reset, active low
    input wire sdc_req_s req_i, // Register access
    output logic [31:0] rdata_o, // Read data, one cycle later
    input wire logic dac_mode_i, // SPI-DAC mode enable
    input wire logic mapped_i, // Mapped DAC values
    input wire sdc_cur_s cur_i, // Scaled currents, start values
    input wire logic update_i, // New current values pulse
    output logic [23:0] switch_vel_o, // Output switch velocity
    output logic [9:0] ofs_a_o, // Coil A value with offset
    output logic sck_o, // DAC serial clock
    output logic cs_n_o, // DAC select, active low
    output logic mosi_o // DAC serial data
);
    typedef struct packed {
        logic [31:0] cmd;
        logic [7:0] ofs;
        logic [31:0] rdata;
        logic [23:0] swvel;
        logic [9:0] ofs_a;
        logic [8:0] cur_b;
        logic pend_a;
        logic pend_b;
        logic start;
        logic [31:0] frame;
    } sdc_regs_s;

    sdc_regs_s q, next_q;
    logic busy;
    logic sck_w;
    logic cs_w;
    logic mosi_w;

    // Offset apply: signed for mapped values, unsigned for absolute
    function automatic logic [9:0] add_ofs(input logic [8:0] cur, input logic [7:0] ofs,
                                            input logic mapped);
        logic [9:0] ext;
        ext = mapped ? {{2{ofs[7]}}, ofs} : {2'b00, ofs};
        add_ofs = {1'b0, cur} + ext;
    endfunction

    // Build one frame: command word then value
    function automatic logic [31:0] mk_frame(input logic [15:0] cmd, input logic [8:0] cur,
                                              input logic [7:0] ofs, input logic mapped);
        mk_frame = {cmd, 6'h00, add_ofs(cur, ofs, mapped)};
    endfunction

    // ------------------------------------------------------------
    // Register access and frame sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        next_q.start = 1'b0;
        if (req_i.wr)
        begin
            if (req_i.addr == `SDC_ADDR_CMD)
            begin
                next_q.cmd = req_i.wdata;
            end
            // (R4) offset from top byte
            if (req_i.addr == `SDC_ADDR_OFS)
            begin
                next_q.ofs = req_i.wdata[`SDC_OFS_LSB +: 8];
            end
        end
        // Reads return the register view; unmapped reads give zero
        next_q.rdata = 32'h0000_0000;
        if (req_i.rd)
        begin
            unique case (req_i.addr)
                `SDC_ADDR_CMD: next_q.rdata = q.cmd;
                // (R6) start values read back
                `SDC_ADDR_OFS: next_q.rdata = {8'h00, cur_i.start_cos, 8'h00, cur_i.sine_start_value};
                `SDC_ADDR_VER: next_q.rdata = {16'h0000, `SDC_VERSION};
                default: next_q.rdata = 32'h0000_0000;
            endcase
        end
        // (R3) velocity view when mode off
        next_q.swvel = dac_mode_i ? 24'h00_0000 : q.cmd[`SDC_SW_VEL_W-1:0];
        // (R5) signed offset when mapped
        next_q.ofs_a = add_ofs(cur_i.cur_a, q.ofs, mapped_i);
        // Latch coil B and flag a new pair; a late update overwrites pending values
        if (update_i && dac_mode_i)
        begin
            next_q.pend_a = 1'b1;
            next_q.pend_b = 1'b1;
            next_q.cur_b = cur_i.cur_b;
        end
        if (!busy && !q.start && dac_mode_i)
        begin
            if (q.pend_a)
            begin
                // (R1) (R7) command A then scaled sine plus offset
                next_q.frame = mk_frame(q.cmd[`SDC_CMD_A_LSB +: 16], cur_i.cur_a, q.ofs,
                                        mapped_i);
                next_q.pend_a = update_i;
                next_q.start = 1'b1;
            end
            else if (q.pend_b)
            begin
                // (R2) command B then coil B
                next_q.frame = mk_frame(q.cmd[`SDC_CMD_B_LSB +: 16], q.cur_b, q.ofs,
                                        mapped_i);
                next_q.pend_b = update_i;
                next_q.start = 1'b1;
            end
        end
    end

    // Register the state
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '{cmd: `SDC_CMD_RST, ofs: `SDC_OFS_RST, rdata: 32'h0000_0000,
                   swvel: 24'h00_0000, ofs_a: 10'h000, cur_b: 9'h000, pend_a: 1'b0,
                   pend_b: 1'b0, start: 1'b0, frame: 32'h0000_0000};
        end
        else
        begin
            q <= next_q;
        end
    end

    // (R8) serial frame engine
    sdc_shifter u_shift (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .start_i(q.start),
        .frame_i(q.frame),
        .busy_o(busy),
        .sck_o(sck_w),
        .cs_n_o(cs_w),
        .mosi_o(mosi_w)
    );

    assign rdata_o = q.rdata;
    assign switch_vel_o = q.swvel;
    assign ofs_a_o = q.ofs_a;
    assign sck_o = sck_w;
    assign cs_n_o = cs_w;
    assign mosi_o = mosi_w;
endmodule

// ### hdl/sdc_shifter.sv
// Serial shifter for one DAC frame: 32 bits, MSB first, in one chip select.
// Assumes a frame start pulse only while busy is low.
`timescale 1ns/10ps
`include "sdc_params.svh"
module sdc_shifter
    import sdc_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic start_i, // Frame start pulse
    input wire logic [31:0] frame_i, // Command then value
    output logic busy_o, // Frame in progress
    output logic sck_o, // Serial clock
    output logic cs_n_o, // Chip select, active low
    output logic mosi_o // Serial data
);
    sdc_shift_s q, next_q;

    // ------------------------------------------------------------
    // Shift sequencing
    // ------------------------------------------------------------
    // Data changes on falling sck, the converter samples on rising
    always_comb
    begin
        next_q = q;
        unique case (q.st)
            SDC_IDLE:
            begin
                // (R8) frame under one select
                if (start_i)
                begin
                    next_q.shreg = frame_i;
                    next_q.bitcnt = 6'(`SDC_FRAME_BITS);
                    next_q.cs_n = 1'b0;
                    next_q.busy = 1'b1;
                    next_q.div = 8'h00;
                    next_q.st = SDC_SHIFT;
                end
            end
            SDC_SHIFT:
            begin
                if (q.div == `SDC_SCK_DIV)
                begin
                    next_q.div = 8'h00;
                    next_q.sck = ~q.sck;
                    if (q.sck)
                    begin
                        next_q.shreg = {q.shreg[30:0], 1'b0};
                        next_q.bitcnt = q.bitcnt - 6'h01;
                        if (q.bitcnt == 6'h01)
                        begin
                            next_q.st = SDC_GAP;
                        end
                    end
                end
                else
                begin
                    next_q.div = q.div + 8'h01;
                end
            end
            SDC_GAP:
            begin
                // Release select only after last bit held one half period
                next_q.cs_n = 1'b1;
                next_q.busy = 1'b0;
                next_q.st = SDC_IDLE;
            end
        endcase
    end

    // Register the state
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '{st: SDC_IDLE, shreg: 32'h0000_0000, bitcnt: 6'h00, div: 8'h00,
                   sck: 1'b0, cs_n: 1'b1, busy: 1'b0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign busy_o = q.busy;
    assign sck_o = q.sck;
    assign cs_n_o = q.cs_n;
    assign mosi_o = q.shreg[31];
endmodule

// ### verif/sdc_dac_model.sv
// Receiving DAC model: takes data on the rising serial clock.
// Assumes flop-driven select, clock and data from the bank.
`timescale 1ns/10ps
module sdc_dac_model
(
    input wire logic sck_i, // Serial clock
    input wire logic cs_n_i, // Select, active low
    input wire logic mosi_i, // Serial data
    output logic [31:0] last_o, // Newest frame
    output logic [31:0] prev_o, // Frame before it
    output int count_o // Whole frames taken
);
    logic [31:0] shift;
    int nbits;
    initial count_o = 0;
    // bit count restarts at each select
    always @(negedge cs_n_i)
        nbits = 0;
    always @(posedge sck_i)
    begin
        if (!cs_n_i)
        begin
            shift = {shift[30:0], mosi_i};
            nbits++;
        end
    end
    // only a whole command-plus-value word is taken
    always @(posedge cs_n_i)
    begin
        if (nbits == 32)
        begin
            prev_o = last_o;
            last_o = shift;
            count_o++;
        end
        nbits = 0;
    end
endmodule

// ### verif/sdc_regs_sva.sv
// Port checker for the SPI-DAC register bank.
// Assumes it is bound to sdc_regs and sees only its ports.
`timescale 1ns/10ps
`include "sdc_params.svh"
module sdc_regs_chk
    import sdc_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic resetn_i, // Reset, active low
    input wire sdc_req_s req_i, // Register access
    input wire logic [31:0] rdata_o, // Read data
    input wire logic dac_mode_i, // Mode enable
    input wire logic mapped_i, // Mapped values
    input wire sdc_cur_s cur_i, // Currents
    input wire logic update_i, // Update pulse
    input wire logic [23:0] switch_vel_o, // Switch velocity
    input wire logic [9:0] ofs_a_o, // Coil A plus offset
    input wire logic sck_o, // Serial clock
    input wire logic cs_n_o, // Select, active low
    input wire logic mosi_o // Serial data
);
    logic [31:0] cmd_sh;
    logic [7:0] ofs_sh;
    logic [7:0] low_cnt;
    logic [9:0] exp_a;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Offset widened by mode; wraps like the design
    assign exp_a = {1'b0, cur_i.cur_a} + {{2{mapped_i & ofs_sh[7]}}, ofs_sh};
    // Shadows of written fields and length of the select pulse
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cmd_sh <= 32'h0;
            ofs_sh <= 8'h0;
            low_cnt <= 8'h0;
        end
        else
        begin
            if (req_i.wr && req_i.addr == `SDC_ADDR_CMD)
                cmd_sh <= req_i.wdata;
            if (req_i.wr && req_i.addr == `SDC_ADDR_OFS)
                ofs_sh <= req_i.wdata[31:24];
            low_cnt <= cs_n_o ? 8'h0 : low_cnt + 8'h1;
        end
    end
    chk_read_idle: assert property (!$past(req_i.rd) |-> rdata_o == 32'h0)
        else $error("read data not zero when idle");
    chk_read_cmd: assert property (
        req_i.rd && req_i.addr == `SDC_ADDR_CMD |=> rdata_o == $past(cmd_sh))
        else $error("command register read wrong");
    chk_read_start: assert property (req_i.rd && req_i.addr == `SDC_ADDR_OFS |=>
        rdata_o == {8'h0, $past(cur_i.start_cos), 8'h0, $past(cur_i.sine_start_value)})
        else $error("start values read wrong");
    chk_read_version: assert property (
        req_i.rd && req_i.addr == `SDC_ADDR_VER |=> rdata_o == {16'h0, `SDC_VERSION})
        else $error("version read wrong");
    chk_switch_on: assert property ($past(dac_mode_i) |-> switch_vel_o == 24'h0)
        else $error("switch velocity live in DAC mode");
    chk_switch_off: assert property (
        !$past(dac_mode_i) |-> switch_vel_o == $past(cmd_sh[23:0]))
        else $error("switch velocity wrong");
    chk_offset_sum: assert property (ofs_a_o == $past(exp_a))
        else $error("coil A offset sum wrong");
    // Select low for 32 four-cycle bits plus the closing gap cycle
    chk_frame_len: assert property ($rose(cs_n_o) |-> low_cnt == 8'd129)
        else $error("frame length wrong");
    chk_sck_idle: assert property (cs_n_o |-> !sck_o)
        else $error("serial clock moves outside frame");
    chk_mosi_edge: assert property (
        !cs_n_o && !$past(cs_n_o) && $changed(mosi_o) |-> $fell(sck_o))
        else $error("data changed off falling clock");
endmodule
bind sdc_regs sdc_regs_chk u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .rdata_o(rdata_o), .dac_mode_i(dac_mode_i), .mapped_i(mapped_i),
    .cur_i(cur_i), .update_i(update_i), .switch_vel_o(switch_vel_o), .ofs_a_o(ofs_a_o),
    .sck_o(sck_o), .cs_n_o(cs_n_o), .mosi_o(mosi_o));

// ### verif/tb_top.sv
// Testbench for the SPI-DAC register bank and its frame output.
// Assumes sdc_regs, the DAC model and the bound checker.
`timescale 1ns/10ps
`include "sdc_params.svh"
module tb_top
    import sdc_pkg::*;
;
    logic sys_clk, resetn, dac_mode, mapped, update, sck, cs_n, mosi;
    sdc_req_s req;
    sdc_cur_s cur;
    logic [31:0] rdata, last, prev;
    logic [23:0] sw_vel;
    logic [9:0] ofs_a;
    int count, n0, failures, n_tests;
    sdc_regs dut (.sys_clk_i(sys_clk), .resetn_i(resetn), .req_i(req), .rdata_o(rdata),
        .dac_mode_i(dac_mode), .mapped_i(mapped), .cur_i(cur), .update_i(update),
        .switch_vel_o(sw_vel), .ofs_a_o(ofs_a), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
    sdc_dac_model dac (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .last_o(last),
        .prev_o(prev), .count_o(count));
    always #20 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %h", $time, what, got);
        end
    endtask
    // Bus tasks start at a falling edge; rd_chk adds an idle cycle after its read
    task automatic access(input logic w, input logic [6:0] a, input logic [31:0] d);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        req = '0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp, input string what);
        access(1'b0, a, 32'h0);
        check(rdata, exp, what);
        @(negedge sys_clk);
    endtask
    task automatic pulse_update();
        update = 1'b1;
        @(negedge sys_clk);
        update = 1'b0;
    endtask
    task automatic wait_frames(input int n);
        for (int i = 0; i < 400 && count < n; i++)
            @(negedge sys_clk);
        if (count < n)
        begin
            failures++;
            $display("BAD %0t frame wait ran out", $time);
            give_verdict();
        end
    endtask
    initial
    begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        req = '0;
        dac_mode = 1'b0;
        mapped = 1'b0;
        cur = '0;
        update = 1'b0;
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        rd_chk(`SDC_ADDR_CMD, 32'h0, "cmd reset");
        rd_chk(`SDC_ADDR_VER, {16'h0, `SDC_VERSION}, "version");
        access(1'b1, `SDC_ADDR_VER, 32'hffff_ffff);
        @(negedge sys_clk);
        rd_chk(`SDC_ADDR_VER, {16'h0, `SDC_VERSION}, "version ro");
        rd_chk(7'h10, 32'h0, "unmapped");
        access(1'b1, `SDC_ADDR_CMD, 32'hbeef_1234);
        @(negedge sys_clk);
        rd_chk(`SDC_ADDR_CMD, 32'hbeef_1234, "cmd");
        check({8'h0, sw_vel}, 32'h00ef_1234, "switch vel");
        dac_mode = 1'b1;
        @(negedge sys_clk);
        check({8'h0, sw_vel}, 32'h0, "switch vel on");
        $display("test registers done");
        access(1'b1, `SDC_ADDR_OFS, 32'hfe12_3456);
        cur = '{cur_a: 9'h105, cur_b: 9'h0f7, sine_start_value: 8'h5a, start_cos: 8'hc3};
        @(negedge sys_clk);
        rd_chk(`SDC_ADDR_OFS, 32'h00c3_005a, "start values");
        check({22'h0, ofs_a}, 32'h203, "unsigned ofs");
        mapped = 1'b1;
        @(negedge sys_clk);
        check({22'h0, ofs_a}, 32'h103, "signed ofs");
        $display("test offset done");
        n0 = count;
        pulse_update();
        wait_frames(n0 + 2);
        check(prev, {16'h1234, 6'h0, 10'h103}, "frame a");
        check(last, {16'hbeef, 6'h0, 10'h0f5}, "frame b");
        dac_mode = 1'b0;
        pulse_update();
        repeat (300) @(negedge sys_clk);
        check(count, n0 + 2, "mode off quiet");
        $display("test frames done");
        give_verdict();
    end
endmodule
